// ### jtp_regs.vh
// Constants for the boundary-scan test access port.
`ifndef JTP_REGS_VH
`define JTP_REGS_VH

// Controller states.
`define JTP_ST_RESET      4'h0
`define JTP_ST_IDLE       4'h1
`define JTP_ST_SEL_DR     4'h2
`define JTP_ST_CAP_DR     4'h3
`define JTP_ST_SHIFT_DR   4'h4
`define JTP_ST_EXIT1_DR   4'h5
`define JTP_ST_PAUSE_DR   4'h6
`define JTP_ST_EXIT2_DR   4'h7
`define JTP_ST_UPD_DR     4'h8
`define JTP_ST_SEL_IR     4'h9
`define JTP_ST_CAP_IR     4'hA
`define JTP_ST_SHIFT_IR   4'hB
`define JTP_ST_EXIT1_IR   4'hC
`define JTP_ST_PAUSE_IR   4'hD
`define JTP_ST_EXIT2_IR   4'hE
`define JTP_ST_UPD_IR     4'hF

// Instruction codes.
`define JTP_IR_W          4
`define JTP_INS_EXTEST    4'h0
`define JTP_INS_SAMPLE    4'h1
`define JTP_INS_IDCODE    4'h2
`define JTP_INS_HIGHZ     4'h3
`define JTP_INS_BYPASS    4'hF
`define JTP_IR_CAPTURE    4'h1

// Identification layout.
`define JTP_ID_W          32
`define JTP_ID_FIXED_ONE  1'h1

// Cycle count of the synchronous reset-pin width filter is not needed; times below are informational.
`define JTP_SYS_PERIOD_NS 8

`endif

// ### jtp_sync.v
// Two-stage synchroniser for pins outside the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module jtp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         resetn,
  // Data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // jtp_sync
`default_nettype wire

// ### jtp_fsm.v
// Test access port controller state machine.
`timescale 1ns/10ps
`default_nettype none
`include "jtp_regs.vh"
module jtp_fsm (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       resetn,
  // Controls
  input  wire       tck_rise,
  input  wire       trst_act,
  input  wire       tms,
  output reg  [3:0] state_q
);

  reg [3:0] state_d;

  always @* begin
    state_d = state_q;
    case (state_q)
      `JTP_ST_RESET:    state_d = tms ? `JTP_ST_RESET    : `JTP_ST_IDLE;
      `JTP_ST_IDLE:     state_d = tms ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
      `JTP_ST_SEL_DR:   state_d = tms ? `JTP_ST_SEL_IR   : `JTP_ST_CAP_DR;
      `JTP_ST_CAP_DR:   state_d = tms ? `JTP_ST_EXIT1_DR : `JTP_ST_SHIFT_DR;
      `JTP_ST_SHIFT_DR: state_d = tms ? `JTP_ST_EXIT1_DR : `JTP_ST_SHIFT_DR;
      `JTP_ST_EXIT1_DR: state_d = tms ? `JTP_ST_UPD_DR   : `JTP_ST_PAUSE_DR;
      `JTP_ST_PAUSE_DR: state_d = tms ? `JTP_ST_EXIT2_DR : `JTP_ST_PAUSE_DR;
      `JTP_ST_EXIT2_DR: state_d = tms ? `JTP_ST_UPD_DR   : `JTP_ST_SHIFT_DR;
      `JTP_ST_UPD_DR:   state_d = tms ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
      `JTP_ST_SEL_IR:   state_d = tms ? `JTP_ST_RESET    : `JTP_ST_CAP_IR;
      `JTP_ST_CAP_IR:   state_d = tms ? `JTP_ST_EXIT1_IR : `JTP_ST_SHIFT_IR;
      `JTP_ST_SHIFT_IR: state_d = tms ? `JTP_ST_EXIT1_IR : `JTP_ST_SHIFT_IR;
      `JTP_ST_EXIT1_IR: state_d = tms ? `JTP_ST_UPD_IR   : `JTP_ST_PAUSE_IR;
      `JTP_ST_PAUSE_IR: state_d = tms ? `JTP_ST_EXIT2_IR : `JTP_ST_PAUSE_IR;
      `JTP_ST_EXIT2_IR: state_d = tms ? `JTP_ST_UPD_IR   : `JTP_ST_SHIFT_IR;
      `JTP_ST_UPD_IR:   state_d = tms ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
      default:          state_d = `JTP_ST_RESET;
    endcase
  end

  // The system reset also puts the controller in test-logic reset, so the port needs no reset of its own after power-up.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= `JTP_ST_RESET;
    end else if (trst_act) begin
      state_q <= `JTP_ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

endmodule // jtp_fsm
`default_nettype wire

// ### jtp_tap.v
// Boundary-scan test access port top level.
`timescale 1ns/10ps
`default_nettype none
`include "jtp_regs.vh"
module jtp_tap #(
  parameter       BSR_LEN   = 8,
  parameter [3:0] ID_VER    = 4'h0,
  parameter [15:0] ID_PART  = 16'h0001, // Arbitrary value.
  parameter [10:0] ID_MAKER = 11'h001   // Arbitrary value.
) (
  // Clock and reset
  input  wire               sys_clk,
  input  wire               resetn,
  // Test port pins
  input  wire               tck,
  input  wire               tms,
  input  wire               tdi,
  input  wire               trst_n,
  output reg                tdo_o,
  output reg                tdo_oe,
  // Chip pin boundary
  input  wire [BSR_LEN-1:0] core_to_pin,
  input  wire [BSR_LEN-1:0] pin_sample,
  output reg  [BSR_LEN-1:0] pin_out_q,
  output reg                pin_float_q,
  output reg                func_enable_q,
  output reg                tap_reset_done_q,
  output reg                idle_active_q
);

  wire [3:0] ins_sync;
  reg        tck_prev_q;
  wire       tck_s;
  wire       tms_s;
  wire       tdi_s;
  wire       trst_act;
  wire [3:0] state;
  wire [BSR_LEN-1:0] pin_sample_s;

  reg  [`JTP_IR_W-1:0] ir_shift_q;
  reg  [`JTP_IR_W-1:0] ir_q;
  reg                  byp_q;
  reg  [`JTP_ID_W-1:0] id_shift_q;
  reg  [BSR_LEN-1:0]   bsr_shift_q;
  reg  [BSR_LEN-1:0]   bsr_upd_q;

  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;

  // The test reset is inverted ahead of the synchroniser so that its cleared state reads as inactive.
  // Otherwise every system reset would look like a test reset pulse for two cycles.
  jtp_sync #(.W(4)) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({tck, tms, tdi, ~trst_n}),
    .sync_out (ins_sync)
  );
  assign tck_s    = ins_sync[3];
  assign tms_s    = ins_sync[2];
  assign tdi_s    = ins_sync[1];
  assign trst_act = ins_sync[0];

  // Pin levels are asynchronous to the system clock as well.
  jtp_sync #(.W(BSR_LEN)) u_sync_pins (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (pin_sample),
    .sync_out (pin_sample_s)
  );

  jtp_fsm u_fsm (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .tck_rise (tck_rise),
    .trst_act (trst_act),
    .tms      (tms_s),
    .state_q  (state)
  );

  // Decoder select functions.
  function sel_bsr;
    input [3:0] ins;
    begin
      sel_bsr = (ins == `JTP_INS_EXTEST) || (ins == `JTP_INS_SAMPLE);
    end
  endfunction

  function sel_id;
    input [3:0] ins;
    begin
      sel_id = (ins == `JTP_INS_IDCODE);
    end
  endfunction

  wire [`JTP_ID_W-1:0] id_word = {ID_VER, ID_PART, ID_MAKER, `JTP_ID_FIXED_ONE};

  // Serial out mux; unlisted codes fall to bypass as the safe minimum path.
  reg tdo_d;
  always @* begin
    if (state == `JTP_ST_SHIFT_IR) begin
      tdo_d = ir_shift_q[0];
    end else if (sel_bsr(ir_q)) begin
      tdo_d = bsr_shift_q[0];
    end else if (sel_id(ir_q)) begin
      tdo_d = id_shift_q[0];
    end else begin
      tdo_d = byp_q;
    end
  end

  always @(posedge sys_clk) begin
    if (!resetn) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  // Instruction path.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ir_shift_q <= `JTP_IR_CAPTURE;
      ir_q       <= `JTP_INS_IDCODE;
    end else if (trst_act || state == `JTP_ST_RESET) begin
      ir_q       <= `JTP_INS_IDCODE;
    end else begin
      if (tck_rise && state == `JTP_ST_CAP_IR) begin
        ir_shift_q <= `JTP_IR_CAPTURE;
      end else if (tck_rise && state == `JTP_ST_SHIFT_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[`JTP_IR_W-1:1]};
      end else begin
        // Pause and exit states leave the shifter untouched.
        ir_shift_q <= ir_shift_q;
      end
      if (tck_fall && state == `JTP_ST_UPD_IR) begin
        ir_q <= ir_shift_q;
      end
    end
  end

  // Data path registers.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      byp_q       <= 1'b0;
      id_shift_q  <= {`JTP_ID_W{1'b0}};
      bsr_shift_q <= {BSR_LEN{1'b0}};
      bsr_upd_q   <= {BSR_LEN{1'b0}};
    end else begin
      if (tck_rise && state == `JTP_ST_CAP_DR) begin
        byp_q       <= 1'b0;
        id_shift_q  <= id_word;
        if (sel_bsr(ir_q)) begin
          bsr_shift_q <= (ir_q == `JTP_INS_EXTEST) ? pin_sample_s : core_to_pin;
        end
      end else if (tck_rise && state == `JTP_ST_SHIFT_DR) begin
        byp_q      <= tdi_s;
        id_shift_q <= {tdi_s, id_shift_q[`JTP_ID_W-1:1]};
        if (sel_bsr(ir_q)) begin
          bsr_shift_q <= {tdi_s, bsr_shift_q[BSR_LEN-1:1]};
        end
      end
      if (tck_fall && state == `JTP_ST_UPD_DR && sel_bsr(ir_q)) begin
        bsr_upd_q <= bsr_shift_q;
      end
    end
  end

  // Outputs to the pins and functional side.
  always @(posedge sys_clk) begin
    if (!resetn) begin
      tdo_o            <= 1'b0;
      tdo_oe           <= 1'b0;
      pin_out_q        <= {BSR_LEN{1'b0}};
      pin_float_q      <= 1'b0;
      func_enable_q    <= 1'b0;
      tap_reset_done_q <= 1'b0;
      idle_active_q    <= 1'b0;
    end else begin
      if (tck_fall) begin
        tdo_o  <= tdo_d;
        tdo_oe <= (state == `JTP_ST_SHIFT_IR) || (state == `JTP_ST_SHIFT_DR);
      end
      if (trst_act || state == `JTP_ST_RESET) begin
        tap_reset_done_q <= 1'b1;
      end
      func_enable_q <= tap_reset_done_q | trst_act | (state == `JTP_ST_RESET);
      pin_out_q     <= (ir_q == `JTP_INS_EXTEST && state != `JTP_ST_RESET) ? bsr_upd_q : core_to_pin;
      pin_float_q   <= (ir_q == `JTP_INS_HIGHZ) && state != `JTP_ST_RESET;
      // No built-in self test exists, so idle stays quiet for every instruction.
      idle_active_q <= 1'b0;
    end
  end

endmodule // jtp_tap
`default_nettype wire

// ### jtp_tap_properties.sv
// Pin-level checks for the test access port.
`timescale 1ns/10ps
`default_nettype none
module jtp_tap_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Test port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  // Status
  input wire logic pin_float_q,
  input wire logic func_enable_q,
  input wire logic tap_reset_done_q,
  input wire logic idle_active_q
);
  logic       tck_q;
  logic [3:0] fall_age_q;
  // The pin is asynchronous, so a move is accepted for a few cycles after the fall is seen.
  wire        near_fall = fall_age_q < 4'h8;
  always_ff @(posedge sys_clk) begin
    tck_q <= tck;
    if (!resetn) begin
      fall_age_q <= 4'hF;
    end else if (tck_q && !tck) begin
      fall_age_q <= 4'h0;
    end else if (fall_age_q != 4'hF) begin
      fall_age_q <= fall_age_q + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_done_after_reset: assert property ($rose(resetn) |-> ##[0:2] tap_reset_done_q)
    else $error("port reset not reached after release");
  a_done_sticky: assert property (tap_reset_done_q |=> tap_reset_done_q)
    else $error("port reset flag dropped");
  a_func_needs_reset: assert property (func_enable_q |-> tap_reset_done_q)
    else $error("function enabled before port reset");
  a_idle_quiet: assert property (!idle_active_q)
    else $error("idle activity without an instruction");
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> near_fall)
    else $error("serial out changed off a fall");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> near_fall)
    else $error("serial enable changed off a fall");
  a_float_on_fall: assert property ($rose(pin_float_q) |-> near_fall)
    else $error("float began off a fall");
  a_trst_clears: assert property (!trst_n [*4] |-> ##[0:4] (!tdo_oe && !pin_float_q && func_enable_q))
    else $error("test reset left test logic active");
  c_shift: cover property ($rose(tdo_oe));
  c_float: cover property ($rose(pin_float_q));
  c_trst: cover property ($fell(trst_n));
endmodule // jtp_tap_properties
bind jtp_tap jtp_tap_properties i_jtp_tap_properties (.sys_clk, .resetn, .tck, .trst_n, .tdo_o,
  .tdo_oe, .pin_float_q, .func_enable_q, .tap_reset_done_q, .idle_active_q);
`default_nettype wire

// ### jtp_tester.sv
// Model of the outside boundary-scan tester.
`timescale 1ns/10ps
`default_nettype none
module jtp_tester (
  // Clock
  input  wire logic sys_clk,
  // Test port
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  // The serial pin has a pull-up, so an undriven pin reads high.
  wire tdo_pin = tdo_oe ? tdo_o : 1'b1;
  initial begin
    {tck, tms, tdi, trst_n} = 4'h5;
  end
  // One 80 ns clock; the clock stands low between steps.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (5) @(negedge sys_clk);
    q = tdo_pin;
    tck = 1'b1;
    repeat (5) @(negedge sys_clk);
    tck = 1'b0;
  endtask
  // Holds the optional test reset low past its minimum width, then waits out its recovery time.
  task automatic pulse_trst();
    @(negedge sys_clk);
    trst_n = 1'b0;
    repeat (7) @(negedge sys_clk);
    trst_n = 1'b1;
    repeat (7) @(negedge sys_clk);
  endtask
  task automatic tlr();
    logic q;
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
  // Shifts n bits from idle, pausing after bit p, and returns to idle.
  task automatic scan(input logic ir, input int n, input int p, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1 || i == p, din[i], q);
      dout[i] = q;
      if (i == p && i != n - 1) begin
        step(1'b0, 1'b0, q);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
      end
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // jtp_tester
`default_nettype wire

// ### jtp_tap_test.sv
// Self-checking bench for the test access port.
`timescale 1ns/10ps
`default_nettype none
module jtp_tap_test;
  localparam logic [3:0]  VER = 4'h2;       // Arbitrary value.
  localparam logic [15:0] PART = 16'h1234;  // Arbitrary value.
  localparam logic [10:0] MAKER = 11'h155;  // Arbitrary value.
  localparam logic [31:0] ID = {VER, PART, MAKER, 1'b1};
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        tck, tms, tdi, trst_n, tdo_o, tdo_oe;
  logic [7:0]  core_to_pin = 8'h5A;
  logic [7:0]  pin_sample = 8'hA5;
  logic [7:0]  pin_out_q;
  logic        pin_float_q, func_enable_q, tap_reset_done_q, idle_active_q;
  logic [31:0] got;
  int          errors = 0;
  int          comparisons = 0;
  jtp_tap #(.BSR_LEN(8), .ID_VER(VER), .ID_PART(PART), .ID_MAKER(MAKER)) i_jtp_tap (
    .sys_clk, .resetn, .tck, .tms, .tdi, .trst_n, .tdo_o, .tdo_oe, .core_to_pin, .pin_sample,
    .pin_out_q, .pin_float_q, .func_enable_q, .tap_reset_done_q, .idle_active_q);
  jtp_tester i_jtp_tester (.sys_clk, .tck, .tms, .tdi, .trst_n, .tdo_o, .tdo_oe);
  initial forever #4 sys_clk = ~sys_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ir(input logic [3:0] c);
    i_jtp_tester.scan(1'b1, 4, 99, {28'h0, c}, got);
  endtask
  task automatic t_reset();
    int n;
    repeat (4) @(negedge sys_clk);
    resetn = 1'b1;
    for (n = 0; n < 10 && tap_reset_done_q !== 1'b1; n++) @(negedge sys_clk);
    if (n == 10) begin
      errors++;
      print_verdict();
    end
    check({tdo_oe, idle_active_q, pin_float_q}, 3'h0);
    i_jtp_tester.tlr();
    check(func_enable_q, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_idcode();
    i_jtp_tester.scan(1'b0, 32, 9, 32'h0, got);
    check(got, ID);
    $display("identification test done");
  endtask
  task automatic t_bypass();
    ir(4'hF);
    check(got[3:0], 4'h1);
    i_jtp_tester.scan(1'b0, 5, 99, 32'h16, got);
    check(got[4:0], 5'h0C);
    check(pin_out_q, core_to_pin);
    $display("bypass test done");
  endtask
  task automatic t_highz();
    ir(4'h3);
    check(pin_float_q, 1'b1);
    i_jtp_tester.scan(1'b0, 3, 99, 32'h7, got);
    check(got[2:0], 3'h6);
    i_jtp_tester.tlr();
    check(pin_float_q, 1'b0);
    $display("float test done");
  endtask
  task automatic t_boundary();
    ir(4'h1);
    i_jtp_tester.scan(1'b0, 8, 99, 32'hC3, got);
    check(got[7:0], core_to_pin);
    check(pin_out_q, core_to_pin);
    ir(4'h0);
    i_jtp_tester.scan(1'b0, 8, 99, 32'h3C, got);
    check(got[7:0], pin_sample);
    check(pin_out_q, 8'h3C);
    i_jtp_tester.tlr();
    check(pin_out_q, core_to_pin);
    $display("boundary test done");
  endtask
  task automatic t_trst();
    ir(4'h7);
    i_jtp_tester.scan(1'b0, 2, 99, 32'h3, got);
    check(got[1:0], 2'h2);
    i_jtp_tester.pulse_trst();
    i_jtp_tester.step(1'b0, 1'b0, got[0]);
    i_jtp_tester.scan(1'b0, 32, 99, 32'h0, got);
    check(got, ID);
    $display("test reset test done");
  endtask
  initial begin
    t_reset();
    t_idcode();
    t_bypass();
    t_highz();
    t_boundary();
    t_trst();
    print_verdict();
  end
endmodule // jtp_tap_test
`default_nettype wire
